// file: core/rffb_defs.svh
// register offsets, field positions and reset values for the fault flag bank
// assumes inclusion by bare name from the design module and the testbench
`ifndef RFFB_DEFS_SVH
`define RFFB_DEFS_SVH

// register offsets
`define RFFB_OFS_CONV_EVT 8'h22
`define RFFB_OFS_BOOST_EVT 8'h23
`define RFFB_OFS_MON_EVT 8'h24
`define RFFB_OFS_LIVE_STAT 8'h25

// converter event field positions
`define RFFB_CONV_ONE_PG 6
`define RFFB_CONV_ONE_SC 5
`define RFFB_CONV_ONE_ILIM 4
`define RFFB_CONV_ZERO_PG 2
`define RFFB_CONV_ZERO_SC 1
`define RFFB_CONV_ZERO_ILIM 0

// boost event field positions
`define RFFB_STEPUP_PG 2
`define RFFB_STEPUP_SC 1
`define RFFB_STEPUP_ILIM 0

// monitor event field positions
`define RFFB_MON_TWO_PG 4
`define RFFB_MON_ONE_PG 2
`define RFFB_ANA_PG 0

// live status field positions
`define RFFB_SYNC_CLK_BAD 3
`define RFFB_THERM_SD 2
`define RFFB_THERM_WARN 1
`define RFFB_OVERVOLT 0

// sticky bit masks and reserved read/write bit masks
`define RFFB_CONV_FLAG_MASK 8'h77
`define RFFB_BOOST_FLAG_MASK 8'h07
`define RFFB_MON_FLAG_MASK 8'h15
`define RFFB_CONV_RSV_MASK 8'h88
`define RFFB_BOOST_RSV_MASK 8'hf8
`define RFFB_MON_RSV_MASK 8'hea

// reset value of every register
`define RFFB_RESET_VAL 8'h00

`endif

// file: core/rffb_pkg.sv
// types shared by the fault flag bank
// assumes rffb_defs.svh on the include path
`default_nettype none
package rffb_pkg;
  typedef logic [7:0] rffb_byte_t;
endpackage : rffb_pkg
`default_nettype wire

// file: core/rffb_flag_bank.sv
// sticky regulator fault flags, live status and summary flags
// assumes a register port already decoded from the serial interface,
// one-cycle write strobe, event inputs synchronous to sys_clk_i
//
// Behaviour
// - converter one power good sets bit six
// - converter one short sets bit five
// - converter one current limit sets bit four
// - converter zero power good sets bit two
// - converter zero short sets bit one
// - converter zero current limit sets bit zero
// - boost power good sets bit two
// - boost short sets bit one
// - boost current limit sets bit zero
// - monitor two power good sets bit four
// - monitor one power good sets bit two
// - analog supply power good sets bit zero
// - status bit three shows bad sync clock
// - status bit two shows thermal shutdown
// - status bit one shows thermal warning
// - status bit zero shows input overvoltage
// - converter summary follows any converter flag
// - boost summary follows any boost flag
// - monitor summary follows any monitor flag
`include "rffb_defs.svh"
`default_nettype none
module rffb_flag_bank
  import rffb_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // converter event pulses
  input wire logic conv_one_power_good_i,
  input wire logic conv_one_short_i,
  input wire logic conv_one_current_limit_i,
  input wire logic conv_zero_power_good_i,
  input wire logic conv_zero_short_i,
  input wire logic conv_zero_current_limit_i,
  // boost event pulses
  input wire logic stepup_power_good_i,
  input wire logic stepup_short_i,
  input wire logic stepup_current_limit_i,
  // monitor event pulses
  input wire logic monitor_two_power_good_i,
  input wire logic monitor_one_power_good_i,
  input wire logic analog_supply_power_good_i,
  // live condition levels
  input wire logic ext_sync_clock_bad_i,
  input wire logic thermal_shutdown_i,
  input wire logic thermal_warning_i,
  input wire logic input_overvoltage_i,
  // summary flags
  output logic conv_summary_flag_o,
  output logic stepup_summary_flag_o,
  output logic monitor_summary_flag_o
);

  rffb_byte_t conv_evt_r;
  rffb_byte_t boost_evt_r;
  rffb_byte_t mon_evt_r;
  rffb_byte_t live_stat_r;
  rffb_byte_t conv_set;
  rffb_byte_t boost_set;
  rffb_byte_t mon_set;
  rffb_byte_t conv_nxt;
  rffb_byte_t boost_nxt;
  rffb_byte_t mon_nxt;
  rffb_byte_t rdata_nxt;
  logic wr_conv;
  logic wr_boost;
  logic wr_mon;

  // event vectors placed at their field positions
  always_comb begin
    conv_set = '0;
    conv_set[`RFFB_CONV_ONE_PG] = conv_one_power_good_i;
    conv_set[`RFFB_CONV_ONE_SC] = conv_one_short_i;
    conv_set[`RFFB_CONV_ONE_ILIM] = conv_one_current_limit_i;
    conv_set[`RFFB_CONV_ZERO_PG] = conv_zero_power_good_i;
    conv_set[`RFFB_CONV_ZERO_SC] = conv_zero_short_i;
    conv_set[`RFFB_CONV_ZERO_ILIM] = conv_zero_current_limit_i;
    boost_set = '0;
    boost_set[`RFFB_STEPUP_PG] = stepup_power_good_i;
    boost_set[`RFFB_STEPUP_SC] = stepup_short_i;
    boost_set[`RFFB_STEPUP_ILIM] = stepup_current_limit_i;
    mon_set = '0;
    mon_set[`RFFB_MON_TWO_PG] = monitor_two_power_good_i;
    mon_set[`RFFB_MON_ONE_PG] = monitor_one_power_good_i;
    mon_set[`RFFB_ANA_PG] = analog_supply_power_good_i;
  end

  // write decode
  assign wr_conv = reg_wr_i && (reg_addr_i == `RFFB_OFS_CONV_EVT);
  assign wr_boost = reg_wr_i && (reg_addr_i == `RFFB_OFS_BOOST_EVT);
  assign wr_mon = reg_wr_i && (reg_addr_i == `RFFB_OFS_MON_EVT);

  // next values: flags clear on one, set wins, reserved bits plain storage
  always_comb begin
    conv_nxt = conv_evt_r;
    boost_nxt = boost_evt_r;
    mon_nxt = mon_evt_r;
    if (wr_conv) begin
      conv_nxt = (conv_evt_r & `RFFB_CONV_FLAG_MASK & ~reg_wdata_i)
        | (reg_wdata_i & `RFFB_CONV_RSV_MASK);
    end
    if (wr_boost) begin
      boost_nxt = (boost_evt_r & `RFFB_BOOST_FLAG_MASK & ~reg_wdata_i)
        | (reg_wdata_i & `RFFB_BOOST_RSV_MASK);
    end
    if (wr_mon) begin
      mon_nxt = (mon_evt_r & `RFFB_MON_FLAG_MASK & ~reg_wdata_i)
        | (reg_wdata_i & `RFFB_MON_RSV_MASK);
    end
    conv_nxt = conv_nxt | conv_set;
    boost_nxt = boost_nxt | boost_set;
    mon_nxt = mon_nxt | mon_set;
  end

  // event registers
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      conv_evt_r <= `RFFB_RESET_VAL;
      boost_evt_r <= `RFFB_RESET_VAL;
      mon_evt_r <= `RFFB_RESET_VAL;
    end else begin
      conv_evt_r <= conv_nxt;
      boost_evt_r <= boost_nxt;
      mon_evt_r <= mon_nxt;
    end
  end

  // live status sampling, no write path
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      live_stat_r <= `RFFB_RESET_VAL;
    end else begin
      live_stat_r <= '0;
      live_stat_r[`RFFB_SYNC_CLK_BAD] <= ext_sync_clock_bad_i;
      live_stat_r[`RFFB_THERM_SD] <= thermal_shutdown_i;
      live_stat_r[`RFFB_THERM_WARN] <= thermal_warning_i;
      live_stat_r[`RFFB_OVERVOLT] <= input_overvoltage_i;
    end
  end

  // summary flags from stored flag bits only
  assign conv_summary_flag_o = |(conv_evt_r & `RFFB_CONV_FLAG_MASK);
  assign stepup_summary_flag_o = |(boost_evt_r & `RFFB_BOOST_FLAG_MASK);
  assign monitor_summary_flag_o = |(mon_evt_r & `RFFB_MON_FLAG_MASK);

  // read mux, unmapped addresses read zero
  always_comb begin
    case (reg_addr_i)
      `RFFB_OFS_CONV_EVT: rdata_nxt = conv_evt_r;
      `RFFB_OFS_BOOST_EVT: rdata_nxt = boost_evt_r;
      `RFFB_OFS_MON_EVT: rdata_nxt = mon_evt_r;
      `RFFB_OFS_LIVE_STAT: rdata_nxt = live_stat_r;
      default: rdata_nxt = '0;
    endcase
  end

  // registered read data
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= `RFFB_RESET_VAL;
    end else begin
      reg_rdata_o <= rdata_nxt;
    end
  end

  // assertions: every event sets its own flag by the next edge
  conv_one_pg_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    conv_one_power_good_i |=> conv_evt_r[6])
    else $error("conv one pg not set");
  conv_one_sc_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    conv_one_short_i |=> conv_evt_r[5])
    else $error("conv one short not set");
  conv_one_ilim_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    conv_one_current_limit_i |=> conv_evt_r[4])
    else $error("conv one ilim not set");
  conv_zero_pg_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    conv_zero_power_good_i |=> conv_evt_r[2])
    else $error("conv zero pg not set");
  conv_zero_sc_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    conv_zero_short_i |=> conv_evt_r[1])
    else $error("conv zero short not set");
  conv_zero_ilim_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    conv_zero_current_limit_i |=> conv_evt_r[0])
    else $error("conv zero ilim not set");
  boost_pg_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    stepup_power_good_i |=> boost_evt_r[2])
    else $error("boost pg not set");
  boost_sc_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    stepup_short_i |=> boost_evt_r[1])
    else $error("boost short not set");
  boost_ilim_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    stepup_current_limit_i |=> boost_evt_r[0])
    else $error("boost ilim not set");
  mon_two_pg_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    monitor_two_power_good_i |=> mon_evt_r[4])
    else $error("mon two pg not set");
  mon_one_pg_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    monitor_one_power_good_i |=> mon_evt_r[2])
    else $error("mon one pg not set");
  ana_pg_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    analog_supply_power_good_i |=> mon_evt_r[0])
    else $error("analog pg not set");

  // live status follows its levels one edge late; the release edge still resets
  sync_clk_stat_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !srst_i |=> (live_stat_r[3] == $past(ext_sync_clock_bad_i)))
    else $error("sync stat wrong");
  therm_sd_stat_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !srst_i |=> (live_stat_r[2] == $past(thermal_shutdown_i)))
    else $error("shutdown stat wrong");
  therm_warn_stat_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !srst_i |=> (live_stat_r[1] == $past(thermal_warning_i)))
    else $error("warning stat wrong");
  overvolt_stat_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !srst_i |=> (live_stat_r[0] == $past(input_overvoltage_i)))
    else $error("input_overvoltage_status wrong");

  // summaries follow the stored flags and drop once the last one is cleared
  conv_summary_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    conv_summary_flag_o == ((conv_evt_r & 8'h77) != 8'h00))
    else $error("conv summary");
  boost_summary_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    stepup_summary_flag_o == ((boost_evt_r & 8'h07) != 8'h00))
    else $error("boost summary");
  mon_summary_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    monitor_summary_flag_o == ((mon_evt_r & 8'h15) != 8'h00))
    else $error("mon summary");
  conv_sum_drop_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (wr_conv && ((conv_evt_r & 8'h77 & ~reg_wdata_i) == 8'h00) && (conv_set == 8'h00))
    |=> !conv_summary_flag_o) else $error("conv summary stuck after clear");
  boost_sum_drop_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (wr_boost && ((boost_evt_r & 8'h07 & ~reg_wdata_i) == 8'h00) && (boost_set == 8'h00))
    |=> !stepup_summary_flag_o) else $error("boost summary stuck after clear");
  mon_sum_drop_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (wr_mon && ((mon_evt_r & 8'h15 & ~reg_wdata_i) == 8'h00) && (mon_set == 8'h00))
    |=> !monitor_summary_flag_o) else $error("mon summary stuck after clear");

  // flags stay until written with one; an event beats a clear
  flag_hold_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (conv_evt_r[6] && !(wr_conv && reg_wdata_i[6])) |=> conv_evt_r[6])
    else $error("flag lost without clear");
  conv_hold_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !wr_conv |=> ((~conv_evt_r & $past(conv_evt_r)) == 8'h00))
    else $error("conv bit dropped without a write");
  boost_hold_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !wr_boost |=> ((~boost_evt_r & $past(boost_evt_r)) == 8'h00))
    else $error("boost bit dropped without a write");
  mon_hold_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !wr_mon |=> ((~mon_evt_r & $past(mon_evt_r)) == 8'h00))
    else $error("mon bit dropped without a write");
  zero_write_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (wr_conv && (reg_wdata_i == 8'h00))
    |=> (conv_evt_r == (($past(conv_evt_r) & 8'h77) | $past(conv_set))))
    else $error("write of zero changed a flag");
  conv_clear_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    wr_conv |=> ((conv_evt_r & 8'h77 & $past(reg_wdata_i) & ~$past(conv_set)) == 8'h00))
    else $error("conv flag not cleared by write one");
  boost_clear_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    wr_boost |=> ((boost_evt_r & 8'h07 & $past(reg_wdata_i) & ~$past(boost_set)) == 8'h00))
    else $error("boost flag not cleared by write one");
  mon_clear_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    wr_mon |=> ((mon_evt_r & 8'h15 & $past(reg_wdata_i) & ~$past(mon_set)) == 8'h00))
    else $error("mon flag not cleared by write one");

  // read data shows the addressed register one edge later
  rd_conv_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (!srst_i && (reg_addr_i == `RFFB_OFS_CONV_EVT)) |=> (reg_rdata_o == $past(conv_evt_r)))
    else $error("conv read data wrong");
  rd_boost_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (!srst_i && (reg_addr_i == `RFFB_OFS_BOOST_EVT)) |=> (reg_rdata_o == $past(boost_evt_r)))
    else $error("boost read data wrong");
  rd_mon_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (!srst_i && (reg_addr_i == `RFFB_OFS_MON_EVT)) |=> (reg_rdata_o == $past(mon_evt_r)))
    else $error("mon read data wrong");
  rd_live_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (!srst_i && (reg_addr_i == `RFFB_OFS_LIVE_STAT)) |=> (reg_rdata_o == $past(live_stat_r)))
    else $error("status read data wrong");

  // reset clears status and converter flags whatever the inputs do
  status_reset_a: assert property (@(posedge sys_clk_i)
    srst_i |=> (live_stat_r == 8'h00 && conv_evt_r == 8'h00))
    else $error("reset value");

  // main scenarios
  clear_by_write_c: cover property (@(posedge sys_clk_i) disable iff (srst_i)
    conv_evt_r[5] ##1 (wr_conv && reg_wdata_i[5]) ##1 !conv_evt_r[5]);
  set_beats_clear_c: cover property (@(posedge sys_clk_i) disable iff (srst_i)
    wr_boost && reg_wdata_i[1] && stepup_short_i);
  summary_drop_c: cover property (@(posedge sys_clk_i) disable iff (srst_i)
    monitor_summary_flag_o ##1 !monitor_summary_flag_o);
  status_rise_c: cover property (@(posedge sys_clk_i) disable iff (srst_i)
    !live_stat_r[2] ##1 live_stat_r[2]);
  all_summaries_c: cover property (@(posedge sys_clk_i) disable iff (srst_i)
    conv_summary_flag_o && stepup_summary_flag_o && monitor_summary_flag_o);

endmodule : rffb_flag_bank
`default_nettype wire

// file: sim/rffb_host_model.sv
// host model: drives the register port of the fault flag bank
// assumes read data registered one cycle after the address, one-cycle write strobe
`default_nettype none
module rffb_host_model (
  // clock
  input wire logic clk_i,
  // register port
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle port at time zero
  initial begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    wdata_o = 8'h00;
  end
  // one write: raised after an edge, taken at the next, then released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wr_o <= 1'b1;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d; // stale data must not look valid
  endtask : wr
  // one read: address held, data taken from the registered answer
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    @(posedge clk_i);
    @(posedge clk_i);
    d = rdata_i;
  endtask : rd
endmodule : rffb_host_model
`default_nettype wire

// file: sim/rffb_flag_bank_bench.sv
// testbench for the fault flag bank: events, clears, live status, reserved bits
// assumes the host model drives the register port; events are driven here
`include "rffb_defs.svh"
`default_nettype none
module rffb_flag_bank_bench;
  import rffb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic srst;
  logic [11:0] ev_r;
  logic [3:0] lv_r;
  logic [7:0] addr;
  logic wr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [2:0] sum;
  int err_total;
  int checks_done;
  int cyc;
  // event bit per input, converter, boost, then monitor
  localparam rffb_byte_t BIT_TBL [12] = '{8'h01, 8'h02, 8'h04, 8'h10, 8'h20, 8'h40,
    8'h01, 8'h02, 8'h04, 8'h01, 8'h04, 8'h10};
  rffb_flag_bank rffb_flag_bank_i (.sys_clk_i(clk), .srst_i(srst), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .conv_zero_current_limit_i(ev_r[0]), .conv_zero_short_i(ev_r[1]),
    .conv_zero_power_good_i(ev_r[2]), .conv_one_current_limit_i(ev_r[3]),
    .conv_one_short_i(ev_r[4]), .conv_one_power_good_i(ev_r[5]),
    .stepup_current_limit_i(ev_r[6]), .stepup_short_i(ev_r[7]),
    .stepup_power_good_i(ev_r[8]), .analog_supply_power_good_i(ev_r[9]),
    .monitor_one_power_good_i(ev_r[10]), .monitor_two_power_good_i(ev_r[11]),
    .input_overvoltage_i(lv_r[0]), .thermal_warning_i(lv_r[1]),
    .thermal_shutdown_i(lv_r[2]), .ext_sync_clock_bad_i(lv_r[3]),
    .conv_summary_flag_o(sum[0]), .stepup_summary_flag_o(sum[1]),
    .monitor_summary_flag_o(sum[2]));
  rffb_host_model rffb_host_model_i (.clk_i(clk), .rdata_i(rdata), .addr_o(addr),
    .wr_o(wr), .wdata_o(wdata));
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // final report and verdict
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      $display("[FAIL] %0t run timed out", $time);
      complete_run();
    end
  end
  task automatic chk(input rffb_byte_t got, input rffb_byte_t exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic rdchk(input rffb_byte_t a, input rffb_byte_t exp);
    rffb_byte_t d;
    rffb_host_model_i.rd(a, d);
    chk(d, exp, $sformatf("read %h", a));
  endtask : rdchk
  // one-cycle event pulse on the selected inputs
  task automatic pulse(input logic [11:0] m);
    @(posedge clk);
    ev_r <= m;
    @(posedge clk);
    ev_r <= 12'h000;
  endtask : pulse
  function automatic rffb_byte_t ofs(input int i);
    return i < 6 ? `RFFB_OFS_CONV_EVT : (i < 9 ? `RFFB_OFS_BOOST_EVT : `RFFB_OFS_MON_EVT);
  endfunction : ofs
  // reset values, unmapped and read-only writes ignored
  task automatic t_reset();
    rffb_host_model_i.wr(8'h30, 8'hff);
    rffb_host_model_i.wr(`RFFB_OFS_LIVE_STAT, 8'hff);
    for (int a = 8'h22; a <= 8'h26; a++) rdchk(8'(a), 8'h00);
    chk({5'h00, sum}, 8'h00, "summaries after reset");
  endtask : t_reset
  // each event sets its own bit, write 0 keeps it, write 1 clears it
  task automatic t_events();
    for (int i = 0; i < 12; i++) begin
      pulse(12'(1 << i));
      rdchk(ofs(i), BIT_TBL[i]);
      chk({5'h00, sum}, 8'(1 << (i < 6 ? 0 : (i < 9 ? 1 : 2))), "summary set");
      rffb_host_model_i.wr(ofs(i), 8'h00);
      rdchk(ofs(i), BIT_TBL[i]);
      rffb_host_model_i.wr(ofs(i), BIT_TBL[i]);
      rdchk(ofs(i), 8'h00);
      chk({5'h00, sum}, 8'h00, "summary cleared");
    end
  endtask : t_events
  // all events at once, summary holds until every flag is gone
  task automatic t_all();
    pulse(12'hfff);
    rdchk(`RFFB_OFS_CONV_EVT, 8'h77);
    rdchk(`RFFB_OFS_BOOST_EVT, 8'h07);
    rdchk(`RFFB_OFS_MON_EVT, 8'h15);
    rffb_host_model_i.wr(`RFFB_OFS_CONV_EVT, 8'h07);
    rdchk(`RFFB_OFS_CONV_EVT, 8'h70);
    chk({5'h00, sum}, 8'h07, "partial clear summary");
    rffb_host_model_i.wr(`RFFB_OFS_CONV_EVT, 8'h70);
    rffb_host_model_i.wr(`RFFB_OFS_BOOST_EVT, 8'h07);
    @(posedge clk);
    chk({5'h00, sum}, 8'h04, "conv and boost cleared");
    rffb_host_model_i.wr(`RFFB_OFS_MON_EVT, 8'h15);
    @(posedge clk);
    chk({5'h00, sum}, 8'h00, "monitor cleared");
  endtask : t_all
  // event in the cycle of a clearing write keeps the flag
  task automatic t_setwins();
    fork
      rffb_host_model_i.wr(`RFFB_OFS_BOOST_EVT, 8'h02);
      pulse(12'h080);
    join
    rdchk(`RFFB_OFS_BOOST_EVT, 8'h02);
    rffb_host_model_i.wr(`RFFB_OFS_BOOST_EVT, 8'h02);
    rdchk(`RFFB_OFS_BOOST_EVT, 8'h00);
  endtask : t_setwins
  // reserved storage reads back and does not raise summaries
  task automatic t_reserved();
    rffb_host_model_i.wr(`RFFB_OFS_CONV_EVT, 8'hff);
    rffb_host_model_i.wr(`RFFB_OFS_MON_EVT, 8'hff);
    rdchk(`RFFB_OFS_CONV_EVT, 8'h88);
    rdchk(`RFFB_OFS_MON_EVT, 8'hea);
    chk({5'h00, sum}, 8'h00, "reserved bits in summary");
    rffb_host_model_i.wr(`RFFB_OFS_CONV_EVT, 8'h00);
    rffb_host_model_i.wr(`RFFB_OFS_MON_EVT, 8'h00);
  endtask : t_reserved
  // live levels show in status, status writes ignored
  task automatic t_status();
    for (int b = 0; b < 4; b++) begin
      @(posedge clk);
      lv_r <= 4'(1 << b);
      rffb_host_model_i.wr(`RFFB_OFS_LIVE_STAT, 8'h00);
      rdchk(`RFFB_OFS_LIVE_STAT, 8'(1 << b));
      @(posedge clk);
      lv_r <= 4'h0;
      rdchk(`RFFB_OFS_LIVE_STAT, 8'h00);
    end
  endtask : t_status
  // reset in mid-run clears flags, reserved storage, status and read data
  task automatic t_midreset();
    pulse(12'hfff);
    rffb_host_model_i.wr(`RFFB_OFS_CONV_EVT, 8'h88);
    chk({5'h00, sum}, 8'h07, "summaries before reset");
    @(posedge clk);
    lv_r <= 4'hf;
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    chk(rdata, 8'h00, "read data in reset");
    chk({5'h00, sum}, 8'h00, "summaries in reset");
    srst <= 1'b0;
    lv_r <= 4'h0;
    for (int a = 8'h22; a <= 8'h25; a++) rdchk(8'(a), 8'h00);
  endtask : t_midreset
  // main sequence
  initial begin
    srst = 1'b1;
    ev_r = 12'h000;
    lv_r = 4'h0;
    err_total = 0;
    checks_done = 0;
    cyc = 0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_events();
    t_all();
    t_setwins();
    t_reserved();
    t_status();
    t_midreset();
    complete_run();
  end
endmodule : rffb_flag_bank_bench
`default_nettype wire
